// ### cpuofd_pkg.sv
// ============================================================
// Overview of operation
// - Instruction length is one to six bytes, by operation and mode.
// - Each flag is kept, cleared, set, or taken from the result.
// - Parity-reporting operations load the parity/overflow flag with parity.
// - Overflow-reporting arithmetic loads parity/overflow flag with signed overflow.
// - Restoring operations reload affected flags from the saved status word.
// - Short-direct byte address selects one RAM byte in FE20h to FF1Fh.
// - Short-direct word address has bit zero clear, same RAM window.
// - Branch displacement is signed eight bits, -128 to +127, added to PC.
// - Short call target is 0800h plus an 11-bit field.
// - Call table entry is 0040h plus twice a 5-bit field.
// - Push/pop mask bits pick pairs; bit five is status word on user stack.
// - Increment/decrement pointer forms use the old value, then step pointer.
// - Index mode adds a 16-bit word to A, B, DE or HL.
// - Bit operand carries a 3-bit bit position within the byte.
// - Low register field picks eight registers; full field picks sixteen.
// - User stack pointer and pair five are one storage.
// - Wide accumulator is the pair of A and X.
// - Status word reads and writes as two separate byte halves.
// - Bit test reaches status word, wide accumulator, special register, short RAM.
package cpuofd_pkg;

	localparam int unsigned APB_AW = 8;

	// ============================================================
	// Register offsets
	localparam logic [7:0] OFF_INSN0 = 8'h00;
	localparam logic [7:0] OFF_INSN1 = 8'h04;
	localparam logic [7:0] OFF_PC = 8'h08;
	localparam logic [7:0] OFF_DECODE = 8'h0c;
	localparam logic [7:0] OFF_EADDR = 8'h10;
	localparam logic [7:0] OFF_PSW = 8'h14;
	localparam logic [7:0] OFF_STATUS_UPPER_HALF = 8'h18;
	localparam logic [7:0] OFF_STATUS_LOWER_HALF = 8'h1c;
	localparam logic [7:0] OFF_FLAGCTL = 8'h20;
	localparam logic [7:0] OFF_RESULT = 8'h24;
	localparam logic [7:0] OFF_SAVED = 8'h28;
	localparam logic [7:0] OFF_SP = 8'h2c;
	localparam logic [7:0] OFF_TEST = 8'h30;
	localparam logic [7:0] OFF_CMD = 8'h34;
	localparam logic [7:0] OFF_PAIR = 8'h40;

	// ============================================================
	// Reset values
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [15:0] RST_SP = 16'h0000;
	localparam logic [15:0] RST_PSW = 16'h0000;

	// ============================================================
	// Address formation
	localparam logic [15:0] SADDR_LO = 16'hfe20;
	localparam logic [15:0] SADDR_HI = 16'hff1f;
	localparam logic [7:0] SADDR_WRAP = 8'h20;
	localparam logic [7:0] SADDR_PG_LO = 8'hfe;
	localparam logic [7:0] SADDR_PG_HI = 8'hff;
	localparam logic [15:0] CALL11_BASE = 16'h0800;
	localparam logic [15:0] CALL11_TOP = 16'h0fff;
	localparam logic [15:0] TABLE_BASE = 16'h0040;
	localparam logic [15:0] TABLE_TOP = 16'h007e;
	localparam logic [2:0] LEN_MIN = 3'h1;
	localparam logic [2:0] LEN_MAX = 3'h6;

	// ============================================================
	// Register pairs
	localparam logic [2:0] PAIR_AX = 3'h0;
	localparam logic [2:0] PAIR_BC = 3'h1;
	localparam logic [2:0] PAIR_VP = 3'h4;
	localparam logic [2:0] PAIR_UP = 3'h5;
	localparam logic [2:0] PAIR_DE = 3'h6;
	localparam logic [2:0] PAIR_HL = 3'h7;

	// ============================================================
	// Status word flag positions and flag control fields
	localparam logic [2:0] FLG_CY = 3'h0;
	localparam logic [2:0] FLG_SUB = 3'h1;
	localparam logic [2:0] FLG_PV = 3'h2;
	localparam logic [2:0] FLG_AC = 3'h4;
	localparam logic [2:0] FLG_Z = 3'h6;
	localparam logic [2:0] FLG_S = 3'h7;
	localparam int unsigned F_S = 0;
	localparam int unsigned F_Z = 1;
	localparam int unsigned F_AC = 2;
	localparam int unsigned F_PV = 3;
	localparam int unsigned F_CY = 4;
	localparam int unsigned F_SUB = 5;
	localparam int unsigned FLAG_CNT = 6;
	localparam int unsigned FCTL_W = 3;
	localparam int unsigned RES_CY = 8;
	localparam int unsigned RES_AC = 9;
	localparam int unsigned RES_OV = 10;
	localparam int unsigned RES_SUB = 11;
	localparam int unsigned CMD_EXEC = 0;

	typedef enum logic [2:0] {
		FA_KEEP = 3'b000,
		FA_ZERO = 3'b001,
		FA_ONE = 3'b010,
		FA_RESULT = 3'b011,
		FA_PARITY = 3'b100,
		FA_OVERFLOW = 3'b101,
		FA_RESTORE = 3'b110
	} cpuofd_flag_act_type;

	typedef enum logic [3:0] {
		CL_REG = 4'b0000,
		CL_SBYTE = 4'b0001,
		CL_SWORD = 4'b0010,
		CL_REL = 4'b0011,
		CL_CALL11 = 4'b0100,
		CL_TABLE = 4'b0101,
		CL_INDIR = 4'b0110,
		CL_BASE = 4'b0111,
		CL_BIDX = 4'b1000,
		CL_INDEX = 4'b1001,
		CL_ABS = 4'b1010,
		CL_STACK = 4'b1011,
		CL_BTEST = 4'b1100,
		CL_LONG5 = 4'b1101,
		CL_LONG6 = 4'b1110,
		CL_SHORT = 4'b1111
	} cpuofd_class_type;

	function automatic logic [2:0] cpuofd_len(input cpuofd_class_type c);
		case (c)
			CL_REG, CL_SHORT: cpuofd_len = 3'h1;
			CL_BASE, CL_BTEST: cpuofd_len = 3'h3;
			CL_INDEX, CL_ABS: cpuofd_len = 3'h4;
			CL_LONG5: cpuofd_len = 3'h5;
			CL_LONG6: cpuofd_len = 3'h6;
			default: cpuofd_len = 3'h2;
		endcase
	endfunction

endpackage

// ### cpuofd_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
module cpuofd_flag_unit
	import cpuofd_pkg::*;
(
	// Current and saved low status byte
	input wire logic [7:0] cur,
	input wire logic [7:0] saved,
	// Per-flag action codes
	input wire logic [FLAG_CNT*FCTL_W-1:0] ctl,
	// Computed result
	input wire logic [7:0] result,
	input wire logic cy,
	input wire logic ac,
	input wire logic ov,
	input wire logic sub,
	// Updated low status byte
	output logic [7:0] nxt
);

	function automatic logic [2:0] pos(input int unsigned i);
		case (i)
			F_S: pos = FLG_S;
			F_Z: pos = FLG_Z;
			F_AC: pos = FLG_AC;
			F_PV: pos = FLG_PV;
			F_CY: pos = FLG_CY;
			default: pos = FLG_SUB;
		endcase
	endfunction

	logic [FLAG_CNT-1:0] res_val;

	always_comb begin
		res_val[F_S] = result[7];
		res_val[F_Z] = ~|result;
		res_val[F_AC] = ac;
		res_val[F_PV] = ov;
		res_val[F_CY] = cy;
		res_val[F_SUB] = sub;
		nxt = cur;
		for (int unsigned i = 0; i < FLAG_CNT; i++) begin
			case (cpuofd_flag_act_type'(ctl[i*FCTL_W +: FCTL_W]))
				FA_ZERO: nxt[pos(i)] = 1'b0;
				FA_ONE: nxt[pos(i)] = 1'b1;
				FA_RESULT: nxt[pos(i)] = res_val[i];
				FA_PARITY: nxt[pos(i)] = ~^result;
				FA_OVERFLOW: nxt[pos(i)] = ov;
				FA_RESTORE: nxt[pos(i)] = saved[pos(i)];
				// Keep, and the one unused code also keeps
				default: nxt[pos(i)] = cur[pos(i)];
			endcase
		end
	end

endmodule
`default_nettype wire

// ### cpuofd_decoder.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cpuofd_decoder
	import cpuofd_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decode results
	output logic [15:0] op_addr,
	output logic [2:0] op_len,
	output logic [15:0] prog_counter
);

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [47:0] insn;
		logic [15:0] pc;
		logic [15:0] program_status_word;
		logic [17:0] fctl;
		logic [15:0] saved;
		logic [15:0] sp;
		logic [7:0][15:0] pair;
		logic [7:0] tdata;
		logic [15:0] ea;
		logic [2:0] len;
		logic misalign;
		logic bitres;
		logic bit5psw;
		logic [3:0] npairs;
	} cpuofd_state_type;

	cpuofd_state_type s_r;
	cpuofd_state_type s_nxt;

	// ============================================================
	// Helpers
	function automatic logic [15:0] saddr_of(input logic [7:0] b);
		// Low 20h bytes wrap into the upper page of the window
		if (b < SADDR_WRAP)
			saddr_of = {SADDR_PG_HI, b};
		else
			saddr_of = {SADDR_PG_LO, b};
	endfunction

	function automatic logic [15:0] rel8(input logic [7:0] d);
		rel8 = {{8{d[7]}}, d};
	endfunction

	function automatic logic [3:0] ones8(input logic [7:0] m);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, m[i]};
		ones8 = n;
	endfunction

	// ============================================================
	// Instruction fields
	logic [7:0] b0, b1, b2, b3;
	cpuofd_class_type cls;
	logic [2:0] len_c;
	logic [15:0] pc_next;
	logic [15:0] de, hl, vp, up, ax;
	logic [7:0] a_reg, b_reg;

	assign b0 = s_r.insn[7:0];
	assign b1 = s_r.insn[15:8];
	assign b2 = s_r.insn[23:16];
	assign b3 = s_r.insn[31:24];
	assign cls = cpuofd_class_type'(b0[7:4]);
	assign len_c = cpuofd_len(cls);
	assign pc_next = s_r.pc + {13'h0000, len_c};
	assign ax = s_r.pair[PAIR_AX];
	assign a_reg = ax[15:8];
	assign b_reg = s_r.pair[PAIR_BC][15:8];
	assign de = s_r.pair[PAIR_DE];
	assign hl = s_r.pair[PAIR_HL];
	assign vp = s_r.pair[PAIR_VP];
	// user stack pointer is pair five
	assign up = s_r.pair[PAIR_UP];

	// ============================================================
	// Address formation
	logic [15:0] ea_c, de_c, hl_c, nptr_c, ptr_c, delta_c;
	logic [3:0] cnt_c;
	logic [7:0] src_c;
	logic misalign_c, hit_c, user_c, pop_c;

	always_comb begin
		ea_c = pc_next;
		de_c = de;
		hl_c = hl;
		misalign_c = 1'b0;
		user_c = b0[0];
		pop_c = b0[1];
		cnt_c = ones8(b1);
		delta_c = {11'h000, cnt_c, 1'b0};
		ptr_c = user_c ? up : s_r.sp;
		nptr_c = pop_c ? ptr_c + delta_c : ptr_c - delta_c;
		case (b1[1:0])
			2'b00: src_c = b1[2] ? s_r.program_status_word[15:8] : s_r.program_status_word[7:0];
			2'b01: src_c = b1[2] ? ax[15:8] : ax[7:0];
			default: src_c = s_r.tdata;
		endcase
		hit_c = src_c[b0[2:0]];
		unique case (cls)
			CL_SBYTE: ea_c = saddr_of(b1);
			CL_SWORD: begin
				ea_c = saddr_of({b1[7:1], 1'b0});
				misalign_c = b1[0];
			end
			CL_REL: ea_c = pc_next + rel8(b1);
			CL_CALL11: ea_c = CALL11_BASE + {5'h00, b0[2:0], b1};
			CL_TABLE: ea_c = TABLE_BASE + {10'h000, b1[4:0], 1'b0};
			CL_INDIR: begin
				unique case (b1[2:0])
					3'b000: ea_c = de;
					3'b001: ea_c = hl;
					3'b010: begin
						ea_c = de;
						de_c = de + 16'h0001;
					end
					3'b011: begin
						ea_c = hl;
						hl_c = hl + 16'h0001;
					end
					3'b100: begin
						ea_c = de;
						de_c = de - 16'h0001;
					end
					3'b101: begin
						ea_c = hl;
						hl_c = hl - 16'h0001;
					end
					3'b110: ea_c = vp;
					3'b111: ea_c = up;
				endcase
			end
			CL_BASE: begin
				unique case (b1[2:0])
					3'b000: ea_c = de + {8'h00, b2};
					3'b001: ea_c = hl + {8'h00, b2};
					3'b010: ea_c = vp + {8'h00, b2};
					3'b011: ea_c = up + {8'h00, b2};
					default: ea_c = s_r.sp + {8'h00, b2};
				endcase
			end
			CL_BIDX: begin
				unique case (b1[2:0])
					3'b000: ea_c = de + {8'h00, a_reg};
					3'b001: ea_c = hl + {8'h00, a_reg};
					3'b010: ea_c = de + {8'h00, b_reg};
					3'b011: ea_c = hl + {8'h00, b_reg};
					3'b100: ea_c = vp + de;
					default: ea_c = vp + hl;
				endcase
			end
			CL_INDEX: begin
				unique case (b1[1:0])
					2'b00: ea_c = {b3, b2} + {8'h00, a_reg};
					2'b01: ea_c = {b3, b2} + {8'h00, b_reg};
					2'b10: ea_c = {b3, b2} + de;
					2'b11: ea_c = {b3, b2} + hl;
				endcase
			end
			CL_ABS: ea_c = {b3, b2};
			// Push starts at the lowered pointer, pop at the current one
			CL_STACK: ea_c = pop_c ? ptr_c : nptr_c;
			CL_BTEST: ea_c = hit_c ? pc_next + rel8(b2) : pc_next;
			CL_REG, CL_LONG5, CL_LONG6, CL_SHORT: ea_c = pc_next;
		endcase
	end

	// ============================================================
	// Flag update
	logic [7:0] flags_nxt;

	cpuofd_flag_unit u_flags (
		.cur(s_r.program_status_word[7:0]),
		.saved(s_r.saved[7:0]),
		.ctl(s_r.fctl),
		.result(pwdata[7:0]),
		.cy(pwdata[RES_CY]),
		.ac(pwdata[RES_AC]),
		.ov(pwdata[RES_OV]),
		.sub(pwdata[RES_SUB]),
		.nxt(flags_nxt)
	);

	// ============================================================
	// Register read decode
	logic [31:0] rd_data;
	logic rd_ok, wr_ok;
	logic [7:0] bitmask;

	assign bitmask = 8'h01 << b0[2:0];

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = (paddr[1:0] == 2'b00);
		wr_ok = 1'b1;
		if (paddr[APB_AW-1:5] == OFF_PAIR[APB_AW-1:5]) begin
			rd_data = {16'h0000, s_r.pair[paddr[4:2]]};
		end else begin
			case (paddr)
				OFF_INSN0: rd_data = s_r.insn[31:0];
				OFF_INSN1: rd_data = {16'h0000, s_r.insn[47:32]};
				OFF_PC: rd_data = {16'h0000, s_r.pc};
				OFF_DECODE: begin
					rd_data = {4'h0, s_r.npairs, 1'b0, b1[2:0], b1[3:0],
						bitmask, 2'b00, s_r.bit5psw, s_r.bitres,
						s_r.misalign, len_c};
					wr_ok = 1'b0;
				end
				OFF_EADDR: begin
					rd_data = {s_r.pc, s_r.ea};
					wr_ok = 1'b0;
				end
				OFF_PSW: rd_data = {16'h0000, s_r.program_status_word};
				OFF_STATUS_UPPER_HALF: rd_data = {24'h000000, s_r.program_status_word[15:8]};
				OFF_STATUS_LOWER_HALF: rd_data = {24'h000000, s_r.program_status_word[7:0]};
				OFF_FLAGCTL: rd_data = {14'h0000, s_r.fctl};
				OFF_RESULT: rd_data = 32'h0000_0000;
				OFF_SAVED: rd_data = {16'h0000, s_r.saved};
				OFF_SP: rd_data = {16'h0000, s_r.sp};
				OFF_TEST: rd_data = {24'h000000, s_r.tdata};
				OFF_CMD: rd_data = 32'h0000_0000;
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// ============================================================
	// Next state
	logic setup, wr_fire, exec_fire, res_fire, status_upper_half_fire;

	assign setup = psel & ~penable;
	assign wr_fire = psel & penable & pwrite & s_r.pready & ~s_r.pslverr;
	assign exec_fire = wr_fire & (paddr == OFF_CMD) & pwdata[CMD_EXEC];
	assign res_fire = wr_fire & (paddr == OFF_RESULT);
	assign status_upper_half_fire = wr_fire & (paddr == OFF_STATUS_UPPER_HALF);

	always_comb begin
		s_nxt = s_r;
		// Answer comes one cycle after setup, from flops
		s_nxt.pready = setup;
		if (setup) begin
			s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_data;
			s_nxt.pslverr = ~rd_ok | (pwrite & ~wr_ok);
		end
		if (wr_fire) begin
			if (paddr[APB_AW-1:5] == OFF_PAIR[APB_AW-1:5]) begin
				s_nxt.pair[paddr[4:2]] = pwdata[15:0];
			end else begin
				case (paddr)
					OFF_INSN0: s_nxt.insn[31:0] = pwdata;
					OFF_INSN1: s_nxt.insn[47:32] = pwdata[15:0];
					OFF_PC: s_nxt.pc = pwdata[15:0];
					OFF_PSW: s_nxt.program_status_word = pwdata[15:0];
					OFF_STATUS_UPPER_HALF: s_nxt.program_status_word[15:8] = pwdata[7:0];
					OFF_STATUS_LOWER_HALF: s_nxt.program_status_word[7:0] = pwdata[7:0];
					OFF_FLAGCTL: s_nxt.fctl = pwdata[17:0];
					OFF_RESULT: s_nxt.program_status_word[7:0] = flags_nxt;
					OFF_SAVED: s_nxt.saved = pwdata[15:0];
					OFF_SP: s_nxt.sp = pwdata[15:0];
					OFF_TEST: s_nxt.tdata = pwdata[7:0];
					default: s_nxt.pc = s_r.pc;
				endcase
			end
		end
		if (exec_fire) begin
			s_nxt.ea = ea_c;
			s_nxt.len = len_c;
			s_nxt.pc = pc_next;
			s_nxt.misalign = (cls == CL_SWORD) & misalign_c;
			s_nxt.bitres = (cls == CL_BTEST) & hit_c;
			s_nxt.bit5psw = 1'b0;
			s_nxt.npairs = 4'h0;
			if (cls == CL_INDIR) begin
				s_nxt.pair[PAIR_DE] = de_c;
				s_nxt.pair[PAIR_HL] = hl_c;
			end
			if (cls == CL_STACK) begin
				// bit five is the status word on the user stack
				s_nxt.bit5psw = user_c & b1[5];
				s_nxt.npairs = cnt_c;
				if (user_c)
					s_nxt.pair[PAIR_UP] = nptr_c;
				else
					s_nxt.sp = nptr_c;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.pc <= RST_PC;
			s_r.sp <= RST_SP;
			s_r.program_status_word <= RST_PSW;
			s_r.len <= LEN_MIN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign op_addr = s_r.ea;
	assign op_len = s_r.len;
	assign prog_counter = s_r.pc;

	// ============================================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_exec_of(cpuofd_class_type c);
		exec_fire && (cls == c);
	endsequence

	property p_apb_answer;
		s_setup |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("access phase without ready");

	property p_len_range;
		exec_fire |=> (op_len >= LEN_MIN) && (op_len <= LEN_MAX);
	endproperty
	a_len_range: assert property (p_len_range)
		else $error("length outside one to six");

	property p_pc_advance;
		exec_fire |=> prog_counter == $past(s_r.pc) + {13'h0000, op_len};
	endproperty
	a_pc_advance: assert property (p_pc_advance)
		else $error("program counter did not advance by length");

	property p_saddr;
		s_exec_of(CL_SBYTE) |=> op_addr >= SADDR_LO && op_addr <= SADDR_HI;
	endproperty
	a_saddr: assert property (p_saddr)
		else $error("short byte address outside window");

	property p_sword;
		s_exec_of(CL_SWORD) |=> !op_addr[0] && op_addr >= SADDR_LO
			&& op_addr <= SADDR_HI;
	endproperty
	a_sword: assert property (p_sword)
		else $error("short word address unaligned or outside");

	property p_branch;
		s_exec_of(CL_REL) |=>
			(op_addr - prog_counter) == rel8($past(b1));
	endproperty
	a_branch: assert property (p_branch)
		else $error("branch target wrong");

	property p_call11;
		s_exec_of(CL_CALL11) |=> op_addr >= CALL11_BASE
			&& op_addr <= CALL11_TOP;
	endproperty
	a_call11: assert property (p_call11)
		else $error("short call target outside range");

	property p_table;
		s_exec_of(CL_TABLE) |=> !op_addr[0] && op_addr >= TABLE_BASE
			&& op_addr <= TABLE_TOP;
	endproperty
	a_table: assert property (p_table)
		else $error("call table address wrong");

	property p_postinc;
		exec_fire && cls == CL_INDIR && b1[2:0] == 3'b010 |=>
			op_addr == $past(de) && de == $past(de) + 16'h0001;
	endproperty
	a_postinc: assert property (p_postinc)
		else $error("post increment wrong");

	property p_flag_zero;
		res_fire && s_r.fctl[F_Z*FCTL_W +: FCTL_W] == FA_ZERO
			|=> !s_r.program_status_word[FLG_Z];
	endproperty
	a_flag_zero: assert property (p_flag_zero)
		else $error("forced zero flag not clear");

	property p_parity;
		res_fire && s_r.fctl[F_PV*FCTL_W +: FCTL_W] == FA_PARITY
			|=> s_r.program_status_word[FLG_PV] == ~^$past(pwdata[7:0]);
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity flag wrong");

	property p_restore;
		res_fire && s_r.fctl[F_CY*FCTL_W +: FCTL_W] == FA_RESTORE
			|=> s_r.program_status_word[FLG_CY] == $past(s_r.saved[FLG_CY]);
	endproperty
	a_restore: assert property (p_restore)
		else $error("carry not restored");

	property p_psw_half;
		status_upper_half_fire |=> s_r.program_status_word[15:8] == $past(pwdata[7:0])
			&& $stable(s_r.program_status_word[7:0]);
	endproperty
	a_psw_half: assert property (p_psw_half)
		else $error("upper half write touched lower half");

endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cpuofd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] op_addr;
	logic [2:0] op_len;
	logic [15:0] prog_counter;
	logic [15:0] pc_m = 16'h0000;
	logic [31:0] rd;
	logic er;
	int mismatches = 0;
	int comparisons = 0;

	always #2.5 pclk = ~pclk;

	cpuofd_decoder u_cpuofd_decoder (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.op_addr(op_addr),
		.op_len(op_len),
		.prog_counter(prog_counter)
	);

	// ============================================================
	// Helpers
	task close_out;
		if (mismatches == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("[ERR] %0t got %h exp %h", $time, g, e);
			mismatches++;
		end
	endtask

	// Read data is taken in the active region, before the slave updates
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20) begin
			mismatches++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// Each execution must move the counter by exactly its length
	task automatic exec(input logic [31:0] i, input logic [2:0] len,
		input logic [15:0] ea, input logic ck);
		wr(OFF_INSN0, i);
		wr(OFF_CMD, 32'h1);
		repeat (2) @(posedge pclk);
		pc_m = pc_m + 16'(len);
		chk({29'h0, op_len}, {29'h0, len});
		chk({16'h0, prog_counter}, {16'h0, pc_m});
		if (ck) begin
			chk({16'h0, op_addr}, {16'h0, ea});
		end
	endtask

	// ============================================================
	// Scenarios
	task t_reset;
		chk({29'h0, op_len}, 32'h1);
		chk({16'h0, prog_counter}, 32'h0);
		rdc(OFF_PSW, 32'h0);
		rdc(OFF_SP, 32'h0);
	endtask

	task t_addr;
		exec(32'h0000_1f10, 3'h2, 16'hff1f, 1'b1);
		exec(32'h0000_2010, 3'h2, 16'hfe20, 1'b1);
		exec(32'h0000_2020, 3'h2, 16'hfe20, 1'b1);
		wr(OFF_PC, 32'h1000);
		pc_m = 16'h1000;
		exec(32'h0000_8030, 3'h2, 16'h0f82, 1'b1);
		exec(32'h0000_7f30, 3'h2, 16'h1083, 1'b1);
		exec(32'h0000_ff47, 3'h2, 16'h0fff, 1'b1);
		exec(32'h0000_0040, 3'h2, 16'h0800, 1'b1);
		exec(32'h0000_1f50, 3'h2, 16'h007e, 1'b1);
		exec(32'h0000_0050, 3'h2, 16'h0040, 1'b1);
	endtask

	task t_modes;
		wr(8'h58, 32'h0010);
		exec(32'h0000_0260, 3'h2, 16'h0010, 1'b1);
		rdc(8'h58, 32'h0011);
		exec(32'h0000_0460, 3'h2, 16'h0011, 1'b1);
		rdc(8'h58, 32'h0010);
		exec(32'h12f0_0290, 3'h4, 16'h1300, 1'b1);
		wr(8'h40, 32'h1234);
		exec(32'h0100_0090, 3'h4, 16'h0112, 1'b1);
		exec(32'h0000_0000, 3'h1, 16'h0, 1'b0);
		exec(32'h0010_01c2, 3'h3, 16'h102c, 1'b1);
		exec(32'h0000_00d0, 3'h5, 16'h0, 1'b0);
		exec(32'h0000_00e0, 3'h6, 16'h0, 1'b0);
	endtask

	task t_stack;
		wr(OFF_SP, 32'h0100);
		exec(32'h0000_21b0, 3'h2, 16'h00fc, 1'b1);
		rdc(OFF_SP, 32'h00fc);
		exec(32'h0000_21b2, 3'h2, 16'h00fc, 1'b1);
		rdc(OFF_SP, 32'h0100);
		wr(8'h54, 32'h2468);
		exec(32'h0000_0760, 3'h2, 16'h2468, 1'b1);
		exec(32'h0000_20b1, 3'h2, 16'h2466, 1'b1);
		rdc(8'h54, 32'h2466);
	endtask

	task t_flags;
		wr(OFF_STATUS_LOWER_HALF, 32'h01);
		wr(OFF_FLAGCTL, 32'h0000_889b);
		wr(OFF_RESULT, 32'h0000_0181);
		rdc(OFF_STATUS_LOWER_HALF, 32'h95);
		wr(OFF_RESULT, 32'h0000_0000);
		rdc(OFF_STATUS_LOWER_HALF, 32'h55);
		wr(OFF_SAVED, 32'h00d7);
		wr(OFF_FLAGCTL, 32'h0003_6db6);
		wr(OFF_RESULT, 32'h0000_0000);
		rdc(OFF_STATUS_LOWER_HALF, 32'hd7);
		wr(OFF_FLAGCTL, 32'h0000_9a49);
		wr(OFF_RESULT, 32'h0000_0400);
		rdc(OFF_STATUS_LOWER_HALF, 32'h04);
		wr(OFF_RESULT, 32'h0000_0000);
		rdc(OFF_STATUS_LOWER_HALF, 32'h00);
	endtask

	task t_psw;
		wr(OFF_STATUS_UPPER_HALF, 32'hab);
		rdc(OFF_PSW, 32'hab00);
		wr(OFF_STATUS_LOWER_HALF, 32'hcd);
		rdc(OFF_PSW, 32'habcd);
		rdc(OFF_STATUS_UPPER_HALF, 32'hab);
	endtask

	// Only the documented decode fields are compared
	task t_decode;
		wr(OFF_INSN0, 32'h0000_0fc5);
		apb(1'b0, OFF_DECODE, 32'h0);
		chk(rd & 32'h00ffff07, 32'h007f2003);
		exec(32'h0000_2120, 3'h2, 16'hfe20, 1'b1);
		apb(1'b0, OFF_DECODE, 32'h0);
		chk(rd & 32'h0000_000f, 32'h0000_000a);
		exec(32'h0000_20b1, 3'h2, 16'h2464, 1'b1);
		apb(1'b0, OFF_DECODE, 32'h0);
		chk(rd & 32'h0000_0020, 32'h0000_0020);
	endtask

	task t_apb;
		apb(1'b0, 8'h3c, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 8'h01, 32'h0);
		chk({31'h0, er}, 32'h1);
		wr(OFF_DECODE, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		rdc(OFF_RESULT, 32'h0);
		chk({31'h0, er}, 32'h0);
	endtask

	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge pclk);
		// The bus cannot answer while reset is held, so only outputs here
		chk({29'h0, op_len}, 32'h1);
		chk({16'h0, prog_counter}, 32'h0);
		chk({16'h0, op_addr}, 32'h0);
		chk({31'h0, pready}, 32'h0);
		chk(prdata, 32'h0);
		presetn <= 1'b1;
		t_reset();
		t_addr();
		t_modes();
		t_stack();
		t_flags();
		t_psw();
		t_decode();
		t_apb();
		close_out();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#(5 * 20000);
		mismatches++;
		close_out();
	end
endmodule
`default_nettype wire
